// *** logic/gpib_port_params.svh ***
`ifndef GPIB_PORT_PARAMS_SVH
`define GPIB_PORT_PARAMS_SVH
// ************************************************************
// bus command codes (low seven data bits, true sense)
// ************************************************************
`define CMD_UNLISTEN 7'h3F
`define CMD_UNTALK 7'h5F
`define CMD_SEC_PRINT 7'h6C
`define CMD_GROUP_MASK 7'h60
`define CMD_GROUP_SEC 7'h60
`define CMD_GROUP_LISTEN 7'h20
// ************************************************************
// interrupt cause bit positions
// ************************************************************
`define IRQ_IFC_BIT 0
`define IRQ_ATN_BIT 1
`define IRQ_HANDSHAKE_INTERRUPT_LINE_BIT 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0
`endif

// *** logic/gpib_port_pkg.sv ***
`default_nettype none
package gpib_port_pkg;
  // operating modes of the port
  typedef enum logic [2:0]
  {
    MODE_IDLE = 3'h1,
    MODE_LISTEN = 3'h2,
    MODE_TALK = 3'h4
  } mode_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// *** logic/bus_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// three-stage input synchroniser with agreement filter
// ************************************************************
module bus_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // raw and clean levels
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] clean_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [W-1:0] clean_d;
  // a bit changes once stages two and three agree
  always_comb
  begin
    clean_d = clean_q;
    for (int i = 0; i < W; i++)
    begin
      if (s2_q[i] == s3_q[i])
        clean_d[i] = s3_q[i];
    end
  end
  // register the chain
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      clean_q <= INIT;
    end
    else
    begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end
  assign clean_o = clean_q;
endmodule // bus_sync
`default_nettype wire

// *** logic/gpib_peripheral_handshake_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gpib_port_params.svh"
// Notes on behaviour
// - idle, attention released: every bus driver but service request off; only attention, clear and remote enable watched
// - listen: drive not-ready and not-accepted; watch valid, data, attention, end
// - talk: drive valid, data and end; watch listener handshake lines
// - service request driven independent of handshake
// - interface clear raises interrupt
// - each attention edge raises interrupt
// - no handshake interrupt while unaddressed, except for bytes under attention
// - listen: interrupt on each valid assertion
// - talk: interrupt when not-ready goes high
// - eight data, three handshake, five management lines
// - valid asserted only while presented byte is valid
// - not-ready held asserted until this listener ready
// - not-accepted held asserted until byte taken
// - bytes under attention are commands, not data
// - interface clear returns port to idle
// - end flag sent with byte and observed by listener
// - unlisten under attention leaves listen mode
// - untalk ignored while listening
// - secondary twelve after listen address announces ascii transfer
// - listen handshake: valid forces not-ready, pulse frees accept
// - talk: pulse sets valid latch, accepted-high clears it
// - attention release enters mode from addressed and direction
// Bus lines are true-sense here (1 = asserted); pads invert.
module gpib_peripheral_handshake_port
  import gpib_port_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // bus data lines
  input wire logic [7:0] dio_i,
  output logic [7:0] dio_o,
  output logic dio_oe_o,
  // bus handshake lines
  input wire logic dav_i,
  output logic dav_o,
  output logic dav_oe_o,
  input wire logic nrfd_i,
  output logic nrfd_o,
  output logic nrfd_oe_o,
  input wire logic ndac_i,
  output logic ndac_o,
  output logic ndac_oe_o,
  // bus management lines
  input wire logic atn_i,
  input wire logic ifc_i,
  input wire logic ren_i,
  input wire logic eoi_i,
  output logic eoi_o,
  output logic eoi_oe_o,
  output logic srq_o,
  output logic srq_oe_o,
  // firmware controls
  input wire logic addressed_i,
  input wire logic talk_sel_i,
  input wire logic shake_i,
  input wire logic srq_req_i,
  input wire gpib_port_pkg::byte_t tx_byte_i,
  input wire logic tx_eoi_i,
  input wire logic [`IRQ_WIDTH-1:0] irq_ack_i,
  // firmware status
  output gpib_port_pkg::byte_t rx_byte_o,
  output logic rx_eoi_o,
  output logic rx_cmd_o,
  output logic ren_o,
  output logic atn_o,
  output logic print_cmd_o,
  output gpib_port_pkg::mode_t mode_o,
  output logic [`IRQ_WIDTH-1:0] irq_pend_o,
  output logic handshake_interrupt_line_o,
  output logic irq_o
);
  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic [7:0] dio_s;
  logic [6:0] ctl_s;
  logic dav_s, nrfd_s, ndac_s, atn_s, ifc_s, ren_s, eoi_s;
  // bus inputs pass four flops before any use
  bus_sync #(.W(8), .INIT(8'h00)) u_sync_dio (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .raw_i(dio_i),
    .clean_o(dio_s)
  );
  bus_sync #(.W(7), .INIT(7'h00)) u_sync_ctl (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .raw_i({dav_i, nrfd_i, ndac_i, atn_i, ifc_i, ren_i, eoi_i}),
    .clean_o(ctl_s)
  );
  assign {dav_s, nrfd_s, ndac_s, atn_s, ifc_s, ren_s, eoi_s} = ctl_s;
  // ************************************************************
  // edge detection
  // ************************************************************
  logic dav_p_q, nrfd_p_q, ndac_p_q, atn_p_q, ifc_p_q;
  logic dav_rise, dav_fall, nrfd_fall, ndac_fall, atn_edge, atn_fall, ifc_rise;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      dav_p_q <= 1'b0;
      nrfd_p_q <= 1'b0;
      ndac_p_q <= 1'b0;
      atn_p_q <= 1'b0;
      ifc_p_q <= 1'b0;
    end
    else
    begin
      dav_p_q <= dav_s;
      nrfd_p_q <= nrfd_s;
      ndac_p_q <= ndac_s;
      atn_p_q <= atn_s;
      ifc_p_q <= ifc_s;
    end
  end
  // edge pulses, one cycle each
  assign dav_rise = dav_s & ~dav_p_q;
  assign dav_fall = ~dav_s & dav_p_q;
  // not-ready and not-accepted go high on the wire when released
  assign nrfd_fall = ~nrfd_s & nrfd_p_q;
  assign ndac_fall = ~ndac_s & ndac_p_q;
  assign atn_edge = atn_s ^ atn_p_q;
  assign atn_fall = ~atn_s & atn_p_q;
  assign ifc_rise = ifc_s & ~ifc_p_q;
  // ************************************************************
  // mode, handshake latches and received byte
  // ************************************************************
  mode_t mode_q, mode_d;
  logic rfd_block_q, rfd_block_d; // forces not-ready asserted
  logic acc_q, acc_d; // one while not-accepted released
  logic dav_lat_q, dav_lat_d;
  logic print_q, print_d;
  logic last_mla_q, last_mla_d;
  byte_t rx_q, rx_d;
  logic rx_eoi_q, rx_eoi_d, rx_cmd_q, rx_cmd_d;
  logic [6:0] cmd7;
  // listen handshake drivers active in listen mode or during commands
  function automatic logic hs_listen(input mode_t m, input logic atn);
    hs_listen = (m == MODE_LISTEN) | atn;
  endfunction
  assign cmd7 = dio_s[6:0];
  always_comb
  begin
    mode_d = mode_q;
    rfd_block_d = rfd_block_q;
    acc_d = acc_q;
    dav_lat_d = dav_lat_q;
    print_d = print_q;
    last_mla_d = last_mla_q;
    rx_d = rx_q;
    rx_eoi_d = rx_eoi_q;
    rx_cmd_d = rx_cmd_q;
    // listen handshake: valid forces not-ready, pulse frees accept
    if (dav_rise && hs_listen(mode_q, atn_s))
    begin
      rfd_block_d = 1'b1;
      rx_d = dio_s;
      rx_eoi_d = eoi_s;
      rx_cmd_d = atn_s;
      if (atn_s && cmd7 == `CMD_UNLISTEN && mode_q == MODE_LISTEN)
        mode_d = MODE_IDLE;
      // untalk leaves a listener untouched
      if (atn_s && cmd7 == `CMD_UNTALK && mode_q == MODE_TALK)
        mode_d = MODE_IDLE;
      // firmware has confirmed its own listen address once the secondary arrives
      if (atn_s && (cmd7 & `CMD_GROUP_MASK) == `CMD_GROUP_SEC)
        print_d = last_mla_q && addressed_i && !talk_sel_i
                  && (cmd7 == `CMD_SEC_PRINT);
      // remember whether the previous command was a primary listen address
      if (atn_s)
        last_mla_d = ((cmd7 & `CMD_GROUP_MASK) == `CMD_GROUP_LISTEN)
                     && (cmd7 != `CMD_UNLISTEN);
    end
    if (shake_i && hs_listen(mode_q, atn_s) && rfd_block_q)
      acc_d = 1'b1;
    if (dav_fall)
    begin
      rfd_block_d = 1'b0;
      acc_d = 1'b0;
    end
    // talk latch, set by pulse and cleared by accepted-high
    if (shake_i && mode_q == MODE_TALK && !atn_s)
      dav_lat_d = 1'b1;
    if (ndac_fall || mode_q != MODE_TALK || atn_s)
      dav_lat_d = 1'b0;
    // attention release picks the mode
    if (atn_fall)
    begin
      if (addressed_i)
        mode_d = talk_sel_i ? MODE_TALK : MODE_LISTEN;
      else
        mode_d = MODE_IDLE;
    end
    // interface clear returns to idle
    if (ifc_s)
    begin
      mode_d = MODE_IDLE;
      rfd_block_d = 1'b0;
      acc_d = 1'b0;
      dav_lat_d = 1'b0;
      print_d = 1'b0;
      last_mla_d = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= MODE_IDLE;
      rfd_block_q <= 1'b0;
      acc_q <= 1'b0;
      dav_lat_q <= 1'b0;
      print_q <= 1'b0;
      last_mla_q <= 1'b0;
      rx_q <= 8'h00;
      rx_eoi_q <= 1'b0;
      rx_cmd_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      rfd_block_q <= rfd_block_d;
      acc_q <= acc_d;
      dav_lat_q <= dav_lat_d;
      print_q <= print_d;
      last_mla_q <= last_mla_d;
      rx_q <= rx_d;
      rx_eoi_q <= rx_eoi_d;
      rx_cmd_q <= rx_cmd_d;
    end
  end
  // ************************************************************
  // bus drivers
  // ************************************************************
  logic lis_drv, tlk_drv;
  assign lis_drv = hs_listen(mode_q, atn_s);
  assign tlk_drv = (mode_q == MODE_TALK) && !atn_s;
  assign nrfd_oe_o = lis_drv;
  assign nrfd_o = lis_drv & rfd_block_q;
  assign ndac_oe_o = lis_drv;
  assign ndac_o = lis_drv & ~acc_q;
  assign dio_oe_o = tlk_drv;
  assign dio_o = tlk_drv ? tx_byte_i : 8'h00;
  assign dav_oe_o = tlk_drv;
  assign dav_o = dav_lat_q;
  assign eoi_oe_o = tlk_drv;
  assign eoi_o = tlk_drv & dav_lat_q & tx_eoi_i;
  assign srq_o = srq_req_i;
  assign srq_oe_o = srq_req_i;
  // ************************************************************
  // interrupt causes
  // ************************************************************
  logic [`IRQ_WIDTH-1:0] pend_q, pend_d, set_v;
  logic handshake_interrupt_line_ev;
  // handshake event in addressed roles and for bytes under attention
  assign handshake_interrupt_line_ev = (mode_q == MODE_LISTEN || atn_s) ? dav_rise
                 : (mode_q == MODE_TALK) ? nrfd_fall : 1'b0;
  always_comb
  begin
    set_v = `IRQ_RESET;
    set_v[`IRQ_IFC_BIT] = ifc_rise;
    set_v[`IRQ_ATN_BIT] = atn_edge;
    set_v[`IRQ_HANDSHAKE_INTERRUPT_LINE_BIT] = handshake_interrupt_line_ev;
    // set wins over acknowledge
    pend_d = (pend_q & ~irq_ack_i) | set_v;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      pend_q <= `IRQ_RESET;
    else
      pend_q <= pend_d;
  end
  assign irq_pend_o = pend_q;
  assign handshake_interrupt_line_o = pend_q[`IRQ_HANDSHAKE_INTERRUPT_LINE_BIT];
  assign irq_o = |pend_q;
  assign rx_byte_o = rx_q;
  assign rx_eoi_o = rx_eoi_q;
  assign rx_cmd_o = rx_cmd_q;
  assign ren_o = ren_s;
  assign atn_o = atn_s;
  assign print_cmd_o = print_q;
  assign mode_o = mode_q;
  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_dav_edge;
    dav_rise && lis_drv;
  endsequence
  a_idle_drivers_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode_q == MODE_IDLE && !atn_s) |-> !(nrfd_oe_o | ndac_oe_o | dio_oe_o | dav_oe_o))
    else $error("driver on while idle");
  a_talk_drives: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode_q == MODE_TALK && !atn_s) |-> (dio_oe_o && dav_oe_o && !nrfd_oe_o))
    else $error("talk drivers wrong");
  a_ifc_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ifc_rise |=> pend_q[`IRQ_IFC_BIT] && irq_o)
    else $error("clear interrupt missing");
  a_atn_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    atn_edge |=> pend_q[`IRQ_ATN_BIT])
    else $error("attention interrupt missing");
  a_idle_no_handshake_interrupt_line: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (mode_q == MODE_IDLE && !atn_s && !pend_q[`IRQ_HANDSHAKE_INTERRUPT_LINE_BIT]) |=> !pend_q[`IRQ_HANDSHAKE_INTERRUPT_LINE_BIT])
    else $error("handshake interrupt while unaddressed");
  a_listen_rfd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_dav_edge ##0 !ifc_s) |=> (nrfd_o || !lis_drv))
    else $error("not-ready not forced");
  a_talk_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ndac_fall && dav_lat_q) |=> !dav_o)
    else $error("valid not removed");
  a_ifc_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ifc_s |=> mode_q == MODE_IDLE)
    else $error("clear did not idle");
  a_pend_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pend_q[`IRQ_ATN_BIT] && !irq_ack_i[`IRQ_ATN_BIT]) |=> pend_q[`IRQ_ATN_BIT])
    else $error("pending cause lost");
endmodule // gpib_peripheral_handshake_port
`default_nettype wire

// *** bench/gpib_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// far side: controller, other talker and other listener
// ************************************************************
module gpib_bus_model (
  // clock
  input wire logic sys_clk_i,
  // port drive, true sense
  input wire logic [7:0] dio_o,
  input wire logic dio_oe_o,
  input wire logic dav_o,
  input wire logic dav_oe_o,
  input wire logic nrfd_o,
  input wire logic nrfd_oe_o,
  input wire logic ndac_o,
  input wire logic ndac_oe_o,
  input wire logic eoi_o,
  input wire logic eoi_oe_o,
  // resolved bus levels
  output logic [7:0] dio_i,
  output logic dav_i,
  output logic nrfd_i,
  output logic ndac_i,
  output logic eoi_i,
  output logic atn_i,
  output logic ifc_i,
  output logic ren_i
);
  logic [7:0] c_dio;
  logic c_dav, c_eoi, c_atn, c_ifc, c_ren, l_nrfd, l_ndac;
  int misses = 0;
  // wired-or of asserted levels; pull-ups leave released lines unasserted
  assign dio_i = c_dio | (dio_oe_o ? dio_o : 8'h00);
  assign dav_i = c_dav | (dav_oe_o & dav_o);
  assign nrfd_i = l_nrfd | (nrfd_oe_o & nrfd_o);
  assign ndac_i = l_ndac | (ndac_oe_o & ndac_o);
  assign eoi_i = c_eoi | (eoi_oe_o & eoi_o);
  assign {atn_i, ifc_i, ren_i} = {c_atn, c_ifc, c_ren};
  // everything released at start
  initial
  begin
    {c_dio, c_dav, c_eoi, c_atn, c_ifc, c_ren, l_nrfd, l_ndac} = '0;
  end
  task automatic tick();
    @(posedge sys_clk_i);
    #2;
  endtask
  // one byte as controller or talker; data settles a cycle before valid
  task automatic send(input logic [7:0] b, input logic e);
    int n;
    for (n = 0; n < 200 && nrfd_i !== 1'b0; n++) tick();
    {c_dio, c_eoi} = {b, e};
    tick();
    c_dav = 1'b1;
    // valid stands long enough for a synchronising listener even if none answers
    repeat (6) tick();
    for (; n < 200 && ndac_i !== 1'b0; n++) tick();
    c_dav = 1'b0;
    tick();
    {c_dio, c_eoi} = 9'h000;
    if (n >= 200) misses++;
  endtask
  // one byte as listener, accepted after d cycles of thought
  task automatic recv(output logic [7:0] b, output logic e, input int d);
    int n;
    l_nrfd = 1'b0;
    for (n = 0; n < 200 && dav_i !== 1'b1; n++) tick();
    {b, e, l_nrfd} = {dio_i, eoi_i, 1'b1};
    repeat (d) tick();
    l_ndac = 1'b0;
    for (; n < 200 && dav_i !== 1'b0; n++) tick();
    l_ndac = 1'b1;
    if (n >= 200) misses++;
  endtask
endmodule // gpib_bus_model
`default_nettype wire

// *** bench/gpib_peripheral_handshake_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gpib_port_params.svh"
// ************************************************************
// bench for the bus handshake port
// ************************************************************
module gpib_peripheral_handshake_port_tb;
  import gpib_port_pkg::*;
  logic sys_clk_i, rst_i, addressed_i, talk_sel_i, shake_i, srq_req_i, tx_eoi_i, fw_on, rxe, rxc, e;
  byte_t tx_byte_i, rx_byte_o, b;
  logic [2:0] ack_fw, ack_main, irq_pend_o;
  logic [7:0] dio_i, dio_o;
  logic dio_oe_o, dav_i, dav_o, dav_oe_o, nrfd_i, nrfd_o, nrfd_oe_o, ndac_i, ndac_o, ndac_oe_o;
  logic atn_i, ifc_i, ren_i, eoi_i, eoi_o, eoi_oe_o, srq_o, srq_oe_o, rx_eoi_o, rx_cmd_o;
  logic ren_o, atn_o, print_cmd_o, handshake_interrupt_line_o, irq_o;
  mode_t mode_o;
  byte_t txq[$], rxq[$], exq[$];
  int err_count = 0;
  int checks_done = 0;
  gpib_peripheral_handshake_port dut (
    .sys_clk_i, .rst_i, .dio_i, .dio_o, .dio_oe_o, .dav_i, .dav_o, .dav_oe_o,
    .nrfd_i, .nrfd_o, .nrfd_oe_o, .ndac_i, .ndac_o, .ndac_oe_o, .atn_i, .ifc_i, .ren_i,
    .eoi_i, .eoi_o, .eoi_oe_o, .srq_o, .srq_oe_o, .addressed_i, .talk_sel_i, .shake_i,
    .srq_req_i, .tx_byte_i, .tx_eoi_i, .irq_ack_i(ack_fw | ack_main), .rx_byte_o,
    .rx_eoi_o, .rx_cmd_o, .ren_o, .atn_o, .print_cmd_o, .mode_o, .irq_pend_o,
    .handshake_interrupt_line_o, .irq_o);
  gpib_bus_model bus (
    .sys_clk_i, .dio_o, .dio_oe_o, .dav_o, .dav_oe_o, .nrfd_o, .nrfd_oe_o, .ndac_o,
    .ndac_oe_o, .eoi_o, .eoi_oe_o, .dio_i, .dav_i, .nrfd_i, .ndac_i, .eoi_i, .atn_i,
    .ifc_i, .ren_i);
  // 40 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic tick();
    @(posedge sys_clk_i);
    #2;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] oe_vec();
    return {dio_oe_o, dav_oe_o, nrfd_oe_o, ndac_oe_o, eoi_oe_o, srq_oe_o, 2'b00};
  endfunction
  task automatic ack(input logic [2:0] m);
    ack_main = m;
    tick();
    ack_main = 3'h0;
  endtask
  task automatic atn_on();
    bus.c_atn = 1'b1;
    repeat (8) tick();
    check({4'h0, atn_o, irq_pend_o}, 8'h0A, "atn on");
    ack(3'h2);
  endtask
  task automatic atn_off(input logic a, input logic t);
    {addressed_i, talk_sel_i} = {a, t};
    bus.c_atn = 1'b0;
    repeat (8) tick();
    check({4'h0, atn_o, irq_pend_o}, 8'h02, "atn off");
    ack(3'h2);
  endtask
  // a bounded wait in the partner ran out
  always @(bus.misses)
  begin
    if (bus.misses > 0)
    begin
      err_count++;
      print_verdict();
    end
  end
  // firmware stand-in: serve the handshake interrupt
  always
  begin
    tick();
    if (fw_on && handshake_interrupt_line_o === 1'b1)
    begin
      if (mode_o !== MODE_TALK)
      begin
        check({6'h00, nrfd_o, ndac_o}, 8'h03, "hold");
        rxq.push_back(rx_byte_o);
        {rxe, rxc, shake_i} = {rx_eoi_o, rx_cmd_o, 1'b1};
      end
      else if (txq.size() > 0)
      begin
        tx_byte_i = txq.pop_front();
        {tx_eoi_i, shake_i} = {txq.size() == 0, 1'b1};
      end
      ack_fw = 3'h4;
      tick();
      {shake_i, ack_fw} = 4'h0;
    end
  end
  // main sequence
  initial
  begin
    {rst_i, addressed_i, talk_sel_i, shake_i, srq_req_i, tx_eoi_i, fw_on} = 7'h40;
    {tx_byte_i, ack_fw, ack_main} = 14'h0000;
    void'($urandom(32'hB57F6D2A));
    repeat (20) tick();
    rst_i = 1'b0;
    tick();
    check(oe_vec(), 8'h00, "reset oe");
    check({4'h0, irq_o, irq_pend_o}, 8'h00, "reset irq");
    fw_on = 1'b1;
    bus.c_ren = 1'b1;
    bus.send(8'h55, 1'b0);
    repeat (8) tick();
    check({5'h00, irq_pend_o}, 8'h00, "idle shake");
    check({7'h00, ren_o}, 8'h01, "ren");
    // addressed as listener with the print secondary
    atn_on();
    bus.send(8'h21, 1'b0);
    check({7'h00, rx_cmd_o}, 8'h01, "cmd");
    // firmware recognises its listen address before the secondary
    {addressed_i, talk_sel_i} = 2'b10;
    bus.send({1'b0, `CMD_SEC_PRINT}, 1'b0);
    check({7'h00, print_cmd_o}, 8'h01, "print");
    atn_off(1'b1, 1'b0);
    check({5'h00, mode_o}, {5'h00, MODE_LISTEN}, "listen");
    check(oe_vec(), 8'h30, "listen oe");
    // data bytes, boundary values first, end flag on the last
    rxq.delete();
    exq = {8'h00, 8'hFF, byte_t'($urandom), byte_t'($urandom), byte_t'($urandom)};
    foreach (exq[i]) bus.send(exq[i], i == 4);
    check(8'(rxq.size()), 8'h05, "rx count");
    foreach (exq[i]) check(rxq[i], exq[i], "rx data");
    check({6'h00, rxe, rxc}, 8'h02, "rx end");
    // untalk ignored, unlisten leaves
    atn_on();
    bus.send({1'b0, `CMD_UNTALK}, 1'b0);
    check({5'h00, mode_o}, {5'h00, MODE_LISTEN}, "untalk");
    bus.send({1'b0, `CMD_UNLISTEN}, 1'b0);
    check({5'h00, mode_o}, {5'h00, MODE_IDLE}, "unlisten");
    atn_off(1'b0, 1'b0);
    check(oe_vec(), 8'h00, "idle oe");
    // addressed as talker, listener slower on each byte
    atn_on();
    bus.send(8'h41, 1'b0);
    exq = {8'hA5, byte_t'($urandom), byte_t'($urandom)};
    txq = exq;
    {bus.l_nrfd, bus.l_ndac} = 2'b11;
    atn_off(1'b1, 1'b1);
    check({5'h00, mode_o}, {5'h00, MODE_TALK}, "talk");
    check(oe_vec(), 8'hC8, "talk oe");
    srq_req_i = 1'b1;
    tick();
    check({6'h00, srq_o, srq_oe_o}, 8'h03, "srq");
    foreach (exq[i])
    begin
      bus.recv(b, e, i * 3);
      check(b, exq[i], "tx data");
      check({7'h00, e}, {7'h00, i == 2}, "tx end");
    end
    // interface clear while talking
    bus.c_ifc = 1'b1;
    repeat (8) tick();
    check({4'h0, irq_o, irq_pend_o}, 8'h09, "ifc irq");
    check({5'h00, mode_o}, {5'h00, MODE_IDLE}, "ifc idle");
    check(oe_vec(), 8'h04, "ifc oe");
    {bus.c_ifc, bus.l_nrfd, bus.l_ndac} = 3'h0;
    repeat (8) tick();
    ack(3'h7);
    tick();
    check({4'h0, irq_o, irq_pend_o}, 8'h00, "ack");
    print_verdict();
  end
endmodule // gpib_peripheral_handshake_port_tb
`default_nettype wire
